// >>> src/amp_mode_startup_sequencer.sv
// Purpose: sleep, mute and start-up sequencing for a two-channel switching amplifier
// Assumes: 40 mclk cycles per microsecond, supply-good and sense pins from comparators
// Notes:   gate outputs follow the modulator only in the run state
//
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module amp_mode_startup_sequencer #(
  parameter int START_CYC_A = amp_seq_pkg::START_CYC_2UF,
  parameter int START_CYC_B = amp_seq_pkg::START_CYC_10UF,
  parameter int START_CYC_C = amp_seq_pkg::START_CYC_30UF,
  parameter int START_CYC_D = amp_seq_pkg::START_CYC_50UF,
  parameter int DETECT_CYC  = amp_seq_pkg::DETECT_CYCLES
) (
  // Clock and reset
  input  wire logic                              mclk,
  input  wire logic                              reset_n,
  // Avalon-MM slave
  input  wire logic [amp_seq_pkg::ADDR_W-1:0]    address,
  input  wire logic                              read,
  input  wire logic                              write,
  input  wire logic [31:0]                       writedata,
  input  wire logic [3:0]                        byteenable,
  output logic      [31:0]                       readdata,
  output logic                                   waitrequest,
  output logic                                   irq,
  // Control pins and supply monitors
  input  wire logic                              sleepPin,
  input  wire logic                              mutePin,
  input  wire logic                              driverSupplyGood,
  input  wire logic                              logicSupplyGood,
  input  wire logic                              logicSupplyDrift,
  // Sense comparators and modulator drive
  input  wire amp_seq_pkg::sense_in_t            senseIn,
  input  wire amp_seq_pkg::gate_drive_t          pwmIn,
  // Gate outputs and status pins
  output amp_seq_pkg::gate_drive_t               gateOut,
  output logic                                   faultWarningOut,
  output logic                                   muteActive,
  output logic                                   internalClockRun
);

  // ----------------------------------------
  // Reset release and pin synchronisation
  // ----------------------------------------
  logic [1:0] rstPipeQ;
  logic       rstN;

  // Reset asserts at once, releases after two clean edges
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      rstPipeQ <= 2'h0;
    else
      rstPipeQ <= {rstPipeQ[0], 1'b1};
  end
  assign rstN = rstPipeQ[1];

  logic                   sleepS;
  logic                   muteS;
  logic                   drvGoodS;
  logic                   logGoodS;
  logic                   driftS;
  amp_seq_pkg::sense_in_t senseS;

  // Every pin crosses two flops before use
  pin_sync #(
    .WIDTH (5 + amp_seq_pkg::SENSE_W)
  ) u_sync (
    .clk     (mclk),
    .rstN    (rstN),
    .pinIn   ({sleepPin, mutePin, driverSupplyGood, logicSupplyGood,
               logicSupplyDrift, senseIn}),
    .syncOut ({sleepS, muteS, drvGoodS, logGoodS, driftS, senseS})
  );

  // ----------------------------------------
  // Software control registers
  // ----------------------------------------
  logic [1:0]                  startSelQ;
  logic                        softMuteQ;
  logic [amp_seq_pkg::IRQ_W-1:0] irqStatQ;
  logic [amp_seq_pkg::IRQ_W-1:0] irqMaskQ;
  logic                        ackQ;
  logic                        wrEn;
  logic                        rdEn;

  // One wait cycle per access, then the answer
  assign waitrequest = (read || write) && !ackQ;
  assign wrEn        = write && ackQ && byteenable[0];
  assign rdEn        = read && !ackQ;

  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
      ackQ <= 1'b0;
    else
      ackQ <= (read || write) && !ackQ;
  end

  // Control register: start time select and software mute
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      startSelQ <= amp_seq_pkg::SEL_RESET;
      softMuteQ <= 1'b0;
    end
    else if (wrEn && address == amp_seq_pkg::OFS_CONTROL)
    begin
      startSelQ <= writedata[amp_seq_pkg::CTL_SEL_LSB +: 2];
      softMuteQ <= writedata[amp_seq_pkg::CTL_SOFTMUTE];
    end
  end

  // Interrupt mask register
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
      irqMaskQ <= '0;
    else if (wrEn && address == amp_seq_pkg::OFS_IRQ_MASK)
      irqMaskQ <= writedata[amp_seq_pkg::IRQ_W-1:0];
  end

  // ----------------------------------------
  // Mode sequencer
  // ----------------------------------------
  amp_seq_pkg::seq_state_t stateQ;
  amp_seq_pkg::seq_state_t stateD;
  logic [amp_seq_pkg::CNT_W-1:0] cntQ;
  logic [amp_seq_pkg::CNT_W-1:0] startTarget;
  logic                          suppliesOk;
  logic                          muteReq;
  logic                          startDone;

  assign suppliesOk = drvGoodS && logGoodS;
  assign muteReq    = muteS || driftS || softMuteQ;

  // Start time chosen by the control register select field, one value per reference capacitor
  always_comb
  begin
    if (startSelQ == 2'h0)
      startTarget = amp_seq_pkg::CNT_W'(START_CYC_A);
    else if (startSelQ == 2'h1)
      startTarget = amp_seq_pkg::CNT_W'(START_CYC_B);
    else if (startSelQ == 2'h2)
      startTarget = amp_seq_pkg::CNT_W'(START_CYC_C);
    else
      startTarget = amp_seq_pkg::CNT_W'(START_CYC_D);
  end

  assign startDone = (cntQ >= startTarget - amp_seq_pkg::CNT_W'(1));

  // Supply loss outranks sleep, sleep outranks everything else
  always_comb
  begin
    stateD = stateQ;
    if (!suppliesOk)
      stateD = amp_seq_pkg::ST_POWER_DOWN;
    else if (sleepS)
      stateD = amp_seq_pkg::ST_SLEEP;
    else
    begin
      case (stateQ)
        amp_seq_pkg::ST_POWER_DOWN: stateD = amp_seq_pkg::ST_STARTING;
        amp_seq_pkg::ST_SLEEP:      stateD = amp_seq_pkg::ST_STARTING;
        amp_seq_pkg::ST_STARTING:
          if (startDone)
            stateD = muteReq ? amp_seq_pkg::ST_MUTED : amp_seq_pkg::ST_RUN;
        amp_seq_pkg::ST_RUN:
          if (muteReq)
            stateD = amp_seq_pkg::ST_MUTED;
        amp_seq_pkg::ST_MUTED:
          if (!muteReq)
            stateD = amp_seq_pkg::ST_STARTING;
        default:    stateD = amp_seq_pkg::ST_POWER_DOWN;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
      stateQ <= amp_seq_pkg::ST_POWER_DOWN;
    else
      stateQ <= stateD;
  end

  // Start counter runs only inside the starting state
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
      cntQ <= '0;
    else if (stateD != amp_seq_pkg::ST_STARTING || stateQ != amp_seq_pkg::ST_STARTING)
      cntQ <= '0;
    else
      cntQ <= cntQ + amp_seq_pkg::CNT_W'(1);
  end

  // ----------------------------------------
  // Gate drive, mute and clock outputs
  // ----------------------------------------
  // Registered from the next state so sleep and mute cut drive in one edge
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      gateOut          <= amp_seq_pkg::GATES_OFF;
      muteActive       <= 1'b1;
      internalClockRun <= 1'b0;
    end
    else
    begin
      gateOut          <= (stateD == amp_seq_pkg::ST_RUN) ? pwmIn : amp_seq_pkg::GATES_OFF;
      muteActive       <= (stateD != amp_seq_pkg::ST_RUN);
      internalClockRun <= (stateD == amp_seq_pkg::ST_RUN);
    end
  end

  // ----------------------------------------
  // Protection
  // ----------------------------------------
  logic [amp_seq_pkg::SENSE_W-1:0] senseEn;
  logic                            faultQ;
  logic                            ocOn;
  logic                            tempOn;

  // Transistors are off outside run, so current sensing is meaningless there
  assign ocOn   = (stateQ == amp_seq_pkg::ST_RUN);
  assign tempOn = (stateQ != amp_seq_pkg::ST_SLEEP) && suppliesOk;
  assign senseEn = {{amp_seq_pkg::SENSE_OC{ocOn}}, tempOn};

  fault_detect #(
    .SRC   (amp_seq_pkg::SENSE_W),
    .DELAY (DETECT_CYC)
  ) u_fault (
    .clk    (mclk),
    .rstN   (rstN),
    .sense  (senseS),
    .enable (senseEn),
    .clear  (sleepS || !suppliesOk),
    .faultQ (faultQ)
  );
  assign faultWarningOut = faultQ;

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  logic                          faultPrevQ;
  logic                          okPrevQ;
  logic                          sleepPrevQ;
  logic [amp_seq_pkg::IRQ_W-1:0] events;
  logic [amp_seq_pkg::IRQ_W-1:0] w1c;

  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      faultPrevQ <= 1'b0;
      okPrevQ    <= 1'b0;
      sleepPrevQ <= 1'b0;
    end
    else
    begin
      faultPrevQ <= faultQ;
      okPrevQ    <= suppliesOk;
      sleepPrevQ <= sleepS;
    end
  end

  always_comb
  begin
    events = '0;
    events[amp_seq_pkg::IRQ_START]  = (stateQ == amp_seq_pkg::ST_STARTING)
                                      && (stateD != amp_seq_pkg::ST_STARTING)
                                      && suppliesOk && !sleepS;
    events[amp_seq_pkg::IRQ_FAULT]  = faultQ && !faultPrevQ;
    events[amp_seq_pkg::IRQ_SUPPLY] = okPrevQ && !suppliesOk;
    events[amp_seq_pkg::IRQ_SLEEP]  = sleepS && !sleepPrevQ;
  end

  assign w1c = (wrEn && address == amp_seq_pkg::OFS_IRQ_STAT)
               ? writedata[amp_seq_pkg::IRQ_W-1:0] : '0;

  // Sticky bits; a new event in the clearing cycle survives
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
      irqStatQ <= '0;
    else
      irqStatQ <= (irqStatQ & ~w1c) | events;
  end

  assign irq = |(irqStatQ & irqMaskQ);

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
      readdata <= '0;
    else if (rdEn)
    begin
      if (address == amp_seq_pkg::OFS_STATUS)
        readdata <= {22'h0, internalClockRun, muteActive, faultQ, logGoodS, drvGoodS,
                     sleepS, muteS, 3'(stateQ)};
      else if (address == amp_seq_pkg::OFS_CONTROL)
        readdata <= {29'h0, softMuteQ, startSelQ};
      else if (address == amp_seq_pkg::OFS_IRQ_STAT)
        readdata <= {28'h0, irqStatQ};
      else if (address == amp_seq_pkg::OFS_IRQ_MASK)
        readdata <= {28'h0, irqMaskQ};
      else
        readdata <= '0; // Unmapped reads as zero
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_sleep_low_ok;
    !sleepS && suppliesOk;
  endsequence

  sequence s_in_starting;
    stateQ == amp_seq_pkg::ST_STARTING;
  endsequence

  property p_sleep_enter;
    @(posedge mclk) disable iff (!rstN)
      (sleepS && suppliesOk) |=> (stateQ == amp_seq_pkg::ST_SLEEP) && muteActive;
  endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered");

  property p_gates_off;
    @(posedge mclk) disable iff (!rstN)
      (stateQ != amp_seq_pkg::ST_RUN) |-> (gateOut == amp_seq_pkg::GATES_OFF);
  endproperty
  a_gates_off: assert property (p_gates_off) else $error("gate drive outside run");

  property p_sleep_clears_fault;
    @(posedge mclk) disable iff (!rstN)
      sleepS |=> !faultWarningOut;
  endproperty
  a_sleep_clears_fault: assert property (p_sleep_clears_fault) else $error("fault held in sleep");

  property p_mute_release;
    @(posedge mclk) disable iff (!rstN)
      (stateQ == amp_seq_pkg::ST_MUTED && !muteReq) ##0 s_sleep_low_ok
        |=> s_in_starting ##0 muteActive;
  endproperty
  a_mute_release: assert property (p_mute_release) else $error("no restart after mute");

  property p_mute_stops_clock;
    @(posedge mclk) disable iff (!rstN)
      muteS |=> !internalClockRun && (stateQ != amp_seq_pkg::ST_RUN);
  endproperty
  a_mute_stops_clock: assert property (p_mute_stops_clock) else $error("clock runs in mute");

  property p_wait_supplies;
    @(posedge mclk) disable iff (!rstN)
      !suppliesOk |=> (stateQ == amp_seq_pkg::ST_POWER_DOWN) && muteActive;
  endproperty
  a_wait_supplies: assert property (p_wait_supplies) else $error("started without supplies");

  property p_hold_mute_start;
    @(posedge mclk) disable iff (!rstN)
      s_in_starting ##0 !startDone |=> muteActive;
  endproperty
  a_hold_mute_start: assert property (p_hold_mute_start) else $error("mute dropped early");

  property p_drift_mutes;
    @(posedge mclk) disable iff (!rstN)
      driftS |=> muteActive && (stateQ != amp_seq_pkg::ST_RUN);
  endproperty
  a_drift_mutes: assert property (p_drift_mutes) else $error("drift did not mute");

  property p_sleep_leave;
    @(posedge mclk) disable iff (!rstN)
      (stateQ == amp_seq_pkg::ST_SLEEP) ##0 s_sleep_low_ok |=> s_in_starting;
  endproperty
  a_sleep_leave: assert property (p_sleep_leave) else $error("no start after sleep");

  property p_start_length;
    @(posedge mclk) disable iff (!rstN)
      $rose(stateQ == amp_seq_pkg::ST_RUN)
        |-> $past(cntQ) == $past(startTarget) - amp_seq_pkg::CNT_W'(1);
  endproperty
  a_start_length: assert property (p_start_length) else $error("start period wrong");

endmodule : amp_mode_startup_sequencer

// >>> include/amp_seq_pkg.sv
// Purpose: shared constants and types for the amplifier mode and start-up sequencer
// Assumes: 40 MHz mclk, Avalon-MM register port with 32-bit data
// Notes:   all timing counts are derived here from times in their own units
// Summary of operation
// - A high sleep input puts the block in sleep, a low one lets it return to normal operation.
// - In sleep every function stops and every gate output sits at its transistor-off level.
// - A high sleep input forces the fault warning output low and clears any latched fault.
// - A falling mute input starts the restart sequence, and running resumes only after it ends.
// - While mute is high the internal clock stops and every gate output is at its off level.
// - After power-up nothing starts until both driver and logic supply-good indications are high.
// - Mute is held through the whole starting period and released only after it has elapsed.
// - A logic-supply deviation of 10% forces mute to avoid turn-off pop.
// - Entering sleep asserts mute in the same instant so switching stops with it.
// - Leaving sleep runs the same starting sequence as power-up before mute is released.
// - Starting time follows the reference capacitor: 0.13 s, 0.33 s, 0.85 s or 1.40 s; here picked by the control register select field.
// - A sense condition that persists for 0.4 us latches the fault warning output high.
// - Overcurrent detection on both channels is suspended in sleep or mute.
// - Over-temperature detection is disabled in sleep.
package amp_seq_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_KHZ          = 40000;
  localparam int DETECT_DELAY_NS  = 400;
  localparam int DETECT_CYCLES    = (DETECT_DELAY_NS * CLK_KHZ + 999999) / 1000000;
  localparam int START_MS_2UF     = 130;
  localparam int START_MS_10UF    = 330;
  localparam int START_MS_30UF    = 850;
  localparam int START_MS_50UF    = 1400;
  localparam int START_CYC_2UF    = START_MS_2UF * CLK_KHZ;
  localparam int START_CYC_10UF   = START_MS_10UF * CLK_KHZ;
  localparam int START_CYC_30UF   = START_MS_30UF * CLK_KHZ;
  localparam int START_CYC_50UF   = START_MS_50UF * CLK_KHZ;
  localparam int CNT_W            = 32;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam int          ADDR_W       = 4;
  localparam logic [3:0]  OFS_STATUS   = 4'h0;
  localparam logic [3:0]  OFS_CONTROL  = 4'h4;
  localparam logic [3:0]  OFS_IRQ_STAT = 4'h8;
  localparam logic [3:0]  OFS_IRQ_MASK = 4'hC;
  localparam logic [1:0]  SEL_RESET    = 2'h0;
  localparam int          CTL_SEL_LSB  = 0;
  localparam int          CTL_SOFTMUTE = 2;
  localparam int          IRQ_W        = 4;
  localparam int          IRQ_START    = 0;
  localparam int          IRQ_FAULT    = 1;
  localparam int          IRQ_SUPPLY   = 2;
  localparam int          IRQ_SLEEP    = 3;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_POWER_DOWN,
    ST_SLEEP,
    ST_STARTING,
    ST_RUN,
    ST_MUTED
  } seq_state_t;

  typedef struct packed {
    logic highP;
    logic highN;
    logic lowP;
    logic lowN;
  } chan_gate_t;

  typedef struct packed {
    chan_gate_t left;
    chan_gate_t right;
  } gate_drive_t;

  typedef struct packed {
    logic ocLeftP;
    logic ocLeftN;
    logic ocRightP;
    logic ocRightN;
    logic thermal;
  } sense_in_t;

  localparam int          SENSE_W   = 5;
  localparam int          SENSE_OC  = 4;
  // P-channel gates off when high, N-channel gates off when low
  localparam chan_gate_t  CHAN_OFF  = 4'hA;
  localparam gate_drive_t GATES_OFF = {CHAN_OFF, CHAN_OFF};

endpackage : amp_seq_pkg

// >>> src/pin_sync.sv
// Purpose: two-flop synchroniser bank for asynchronous pins
// Assumes: inputs are levels, slower than the clock
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstN,
  // Pins
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1Q;

  // Two flops to settle metastability
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      stage1Q <= '0;
      syncOut <= '0;
    end
    else
    begin
      stage1Q <= pinIn;
      syncOut <= stage1Q;
    end
  end

endmodule : pin_sync

// >>> src/fault_detect.sv
// Purpose: persistence filters on sense inputs and the latched fault warning
// Assumes: sense and enable inputs already synchronous to clk
// Notes:   clear beats any set, the warning is forced low while clear is high
`timescale 1ns/1ps
module fault_detect #(
  parameter int SRC    = 5,
  parameter int DELAY  = amp_seq_pkg::DETECT_CYCLES
) (
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           rstN,
  // Sense conditions
  input  wire logic [SRC-1:0] sense,
  input  wire logic [SRC-1:0] enable,
  input  wire logic           clear,
  // Latched warning
  output logic                faultQ
);

  localparam int CW = $clog2(DELAY + 1);
  localparam logic [CW-1:0] LAST = CW'(DELAY - 1);

  logic [SRC-1:0] hit;

  // One persistence counter per source; disabled sources hold at zero
  generate
    for (genvar i = 0; i < SRC; i++)
    begin : g_src
      logic [CW-1:0] runQ;
      always_ff @(posedge clk or negedge rstN)
      begin
        if (!rstN)
          runQ <= '0;
        else if (!(sense[i] && enable[i]))
          runQ <= '0;
        else if (runQ != LAST)
          runQ <= runQ + CW'(1);
      end
      assign hit[i] = sense[i] && enable[i] && (runQ == LAST);
    end
  endgenerate

  // Warning latch, clear wins to match the forced-low behaviour in sleep
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      faultQ <= 1'b0;
    else if (clear)
      faultQ <= 1'b0;
    else if (|hit)
      faultQ <= 1'b1;
  end

  property p_fault_latch;
    @(posedge clk) disable iff (!rstN)
      (|hit && !clear) |=> faultQ;
  endproperty
  a_fault_latch: assert property (p_fault_latch) else $error("fault not latched");

  property p_fault_no_early;
    @(posedge clk) disable iff (!rstN)
      (!faultQ && !(|hit)) |=> !faultQ;
  endproperty
  a_fault_no_early: assert property (p_fault_no_early) else $error("early fault");

endmodule : fault_detect

// >>> testbench/gate_drive_model.sv
// Purpose: modulator stand-in feeding the gate-drive path of the sequencer
// Assumes: free running on mclk like a real modulator
// Notes:   pattern flips every cycle so a stuck gate output shows at once
`timescale 1ns/1ps
module gate_drive_model (
  // Clock
  input  wire logic                mclk,
  // Drive toward the sequencer and its one-cycle-old copy
  output amp_seq_pkg::gate_drive_t pwmIn,
  output amp_seq_pkg::gate_drive_t pwmPrev
);
  // ----------------------------------------
  // Pattern source
  // ----------------------------------------
  // Never equal to the off pattern, so a forced-off output is distinct
  // One process owns both outputs, so each has a single driver
  initial
  begin
    pwmIn   = 8'h66;
    pwmPrev = 8'h00;
    forever
    begin
      @(posedge mclk);
      pwmIn   <= ~pwmIn;
      pwmPrev <= pwmIn;
    end
  end
endmodule : gate_drive_model

// >>> testbench/tb_top.sv
// Purpose: self-checking bench for the amplifier mode and start-up sequencer
// Assumes: shortened start and detect counts, inputs driven at mclk rise
// Notes:   outputs sampled at the falling edge, where they have settled
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int START_A = 40;
  localparam int START_B = 60;
  localparam int START_C = 80;
  localparam int START_D = 100;
  logic                     mclk, reset_n, read, write, waitrequest, irq;
  logic                     sleepPin, mutePin, drvGood, logGood, drift;
  logic                     faultWarningOut, muteActive, clockRun;
  logic [3:0]               address;
  logic [31:0]              writedata, readdata, rd;
  amp_seq_pkg::sense_in_t   sense;
  amp_seq_pkg::gate_drive_t pwmIn, pwmPrev, gateOut;
  int                       errTotal, nChecks, cyc, n;

  amp_mode_startup_sequencer #(.START_CYC_A(START_A), .START_CYC_B(START_B),
    .START_CYC_C(START_C), .START_CYC_D(START_D), .DETECT_CYC(4)) dut_u (
    .mclk(mclk), .reset_n(reset_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq), .sleepPin(sleepPin), .mutePin(mutePin),
    .driverSupplyGood(drvGood), .logicSupplyGood(logGood), .logicSupplyDrift(drift),
    .senseIn(sense), .pwmIn(pwmIn), .gateOut(gateOut), .faultWarningOut(faultWarningOut),
    .muteActive(muteActive), .internalClockRun(clockRun));
  gate_drive_model model_u (.mclk(mclk), .pwmIn(pwmIn), .pwmPrev(pwmPrev));

  // ----------------------------------------
  // Clock, sampling and timeout
  // ----------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errTotal++;
      report_and_stop;
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    nChecks++;
    if (got !== exp)
    begin
      errTotal++;
      $display("BAD %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask : chk
  // Holds the request until waitrequest is seen low at a rising edge
  // Sampled in the edge's active step, before the slave's own updates land
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do
    begin
      @(posedge mclk);
    end
    while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic settle(input int k);
    repeat (k) @(posedge mclk);
    @(negedge mclk);
  endtask : settle
  // No fixed latency assumed, the count itself is checked
  task automatic waitRun(output int c);
    c = 0;
    while (muteActive !== 1'b0 && c < 300)
    begin
      @(negedge mclk);
      c++;
    end
  endtask : waitRun
  task automatic report_and_stop;
    $display("checks %0d errors %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    {reset_n, read, write, sleepPin, mutePin, drvGood, logGood, drift} = '0;
    address = 4'h0;
    writedata = 32'h0;
    sense = 5'h00;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    settle(4);
    chk(gateOut, amp_seq_pkg::GATES_OFF, "off at reset");
    bus(1'b1, amp_seq_pkg::OFS_IRQ_MASK, 32'hF);
    @(posedge mclk) drvGood <= 1'b1;
    settle(10);
    chk(muteActive, 32'h1, "one supply only");
    @(posedge mclk) logGood <= 1'b1;
    waitRun(n);
    chk(32'(n >= START_A && n <= START_A + 6), 32'h1, "start length A");
    chk(clockRun, 32'h1, "clock runs");
    chk(gateOut, pwmPrev, "gates follow modulator");
    bus(1'b0, amp_seq_pkg::OFS_IRQ_STAT, 32'h0);
    chk(rd, 32'h1, "start event");
    bus(1'b1, amp_seq_pkg::OFS_IRQ_STAT, 32'h1);
    settle(0);
    chk(irq, 32'h0, "event cleared");
    // Pulse shorter than the persistence filter must not latch
    @(posedge mclk) sense <= 5'h01;
    repeat (2) @(posedge mclk);
    sense <= 5'h00;
    settle(8);
    chk(faultWarningOut, 32'h0, "short pulse");
    @(posedge mclk) sense <= 5'h01;
    settle(10);
    chk(faultWarningOut, 32'h1, "fault latched");
    chk(irq, 32'h1, "fault event");
    @(posedge mclk) sleepPin <= 1'b1;
    settle(4);
    chk(faultWarningOut, 32'h0, "sleep clears");
    chk(muteActive, 32'h1, "sleep mutes");
    chk(gateOut, amp_seq_pkg::GATES_OFF, "sleep gates");
    bus(1'b0, amp_seq_pkg::OFS_STATUS, 32'h0);
    chk({29'h0, rd[2:0]}, 32'h1, "sleep state");
    bus(1'b1, amp_seq_pkg::OFS_CONTROL, 32'h1);
    @(posedge mclk) sleepPin <= 1'b0;
    sense <= 5'h00;
    waitRun(n);
    chk(32'(n >= START_B && n <= START_B + 6), 32'h1, "start length B");
    // Overcurrent while muted must be ignored
    @(posedge mclk) mutePin <= 1'b1;
    sense <= 5'h10;
    settle(10);
    chk(faultWarningOut, 32'h0, "oc in mute");
    chk(clockRun, 32'h0, "clock stopped");
    chk(gateOut, amp_seq_pkg::GATES_OFF, "mute gates");
    @(posedge mclk) mutePin <= 1'b0;
    sense <= 5'h00;
    waitRun(n);
    chk(32'(n >= START_B && n <= START_B + 6), 32'h1, "restart length");
    // Remaining capacitor options, each reached through a mute restart
    for (int s = 2; s < 4; s++)
    begin
      bus(1'b1, amp_seq_pkg::OFS_CONTROL, 32'(s));
      @(posedge mclk) mutePin <= 1'b1;
      settle(4);
      @(posedge mclk) mutePin <= 1'b0;
      waitRun(n);
      chk(32'(n >= (s == 2 ? START_C : START_D) && n <= (s == 2 ? START_C : START_D) + 6),
          32'h1, "start length C D");
    end
    @(posedge mclk) drift <= 1'b1;
    settle(4);
    chk(muteActive, 32'h1, "drift mutes");
    @(posedge mclk) drift <= 1'b0;
    logGood <= 1'b0;
    settle(4);
    chk(gateOut, amp_seq_pkg::GATES_OFF, "supply lost");
    bus(1'b0, amp_seq_pkg::OFS_STATUS, 32'h0);
    chk({29'h0, rd[2:0]}, 32'h0, "power-down state");
    bus(1'b0, 4'h1, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    report_and_stop;
  end
endmodule : tb_top
